//--- core/psf_alu.sv
// Arithmetic and logic unit with flag generation
`timescale 1ns/100ps
module psf_alu
	import psf_pkg::*;
#(
	parameter int unsigned WIDTH = FLAG_W
) (
	input  wire psf_op_e                  op,        // Operation
	input  wire logic [WIDTH-1:0]         w_val,     // Working value
	input  wire logic [WIDTH-1:0]         file_val,  // File operand
	input  wire logic [WIDTH-1:0]         lit_val,   // Literal operand
	input  wire logic [$clog2(WIDTH)-1:0] bit_sel,   // Bit index
	input  wire logic                     carry_in,  // Current carry flag
	output logic      [WIDTH-1:0]         result,    // Result
	output psf_flags_s                    flags,     // Computed flags
	output psf_flags_s                    touch      // Flags this op updates
);

	if (WIDTH <= NIB_W) begin : g_bad_width
		$error("psf_alu: WIDTH must exceed the nibble width");
	end

	logic [WIDTH-1:0] opa;
	logic [WIDTH-1:0] opb;
	logic             cin;
	logic [WIDTH:0]   sum;
	logic [NIB_W:0]   low;
	logic [WIDTH-1:0] onehot;

	always_comb begin
		opa = file_val;
		opb = w_val;
		cin = 1'b0;
		case (op)
			OP_ADD_LITERAL: begin
				opa = lit_val;
			end
			OP_SUB_FROM_LITERAL: begin
				opa = lit_val;
				opb = ~w_val;
				cin = 1'b1;
			end
			OP_SUB_W_FILE: begin
				opb = ~w_val;
				cin = 1'b1;
			end
			default: begin
				opa = file_val;
			end
		endcase
		sum = {1'b0, opa} + {1'b0, opb} + {{WIDTH{1'b0}}, cin};
		low = {1'b0, opa[NIB_W-1:0]} + {1'b0, opb[NIB_W-1:0]} + {{NIB_W{1'b0}}, cin};
		onehot = {{(WIDTH-1){1'b0}}, 1'b1} << bit_sel;
		result = sum[WIDTH-1:0];
		touch = '0;
		flags.msb_ovf = sum[WIDTH];
		flags.nibble_carry = low[NIB_W];
		case (op)
			OP_ADD_W_FILE, OP_ADD_LITERAL, OP_SUB_FROM_LITERAL, OP_SUB_W_FILE: begin
				touch = '1;
			end
			OP_AND_W_FILE: begin
				result = w_val & file_val;
				touch.null_res = 1'b1;
			end
			OP_OR_W_FILE: begin
				result = w_val | file_val;
				touch.null_res = 1'b1;
			end
			OP_XOR_W_FILE: begin
				result = w_val ^ file_val;
				touch.null_res = 1'b1;
			end
			OP_CLEAR_FILE: begin
				result = '0;
				touch.null_res = 1'b1;
			end
			OP_MOVE_W_TO_FILE: result = w_val;
			OP_BIT_CLEAR:      result = file_val & ~onehot;
			OP_BIT_SET:        result = file_val | onehot;
			OP_NIBBLE_SWAP:    result = {file_val[NIB_W-1:0], file_val[WIDTH-1:NIB_W]};
			OP_ROTATE_RIGHT: begin
				result = {carry_in, file_val[WIDTH-1:1]};
				flags.msb_ovf = file_val[0];
				touch.msb_ovf = 1'b1;
			end
			OP_ROTATE_LEFT: begin
				result = {file_val[WIDTH-2:0], carry_in};
				flags.msb_ovf = file_val[WIDTH-1];
				touch.msb_ovf = 1'b1;
			end
			default: result = file_val;
		endcase
		flags.null_res = (result == '0);
	end

endmodule

//--- core/psf_pkg.sv
// Shared constants and types for the processor status flag block
package psf_pkg;

	localparam int unsigned FLAG_W = 8;
	localparam int unsigned NIB_W  = 4;
	localparam int unsigned ADDR_W = 12;

	// Bit positions inside processor_flags
	localparam int unsigned BIT_MSB_OVF   = 0;
	localparam int unsigned BIT_NIBBLE    = 1;
	localparam int unsigned BIT_NULL      = 2;
	localparam int unsigned BIT_PWR_DOWN  = 3;
	localparam int unsigned BIT_TIMEOUT   = 4;
	localparam int unsigned BIT_BANK      = 5;
	localparam int unsigned BIT_UPPER_RSV = 6;
	localparam int unsigned BIT_IND_RSV   = 7;

	localparam logic [7:0] FLAGS_RST     = 8'h18;
	localparam logic [7:0] HW_ONLY_MASK  = 8'h18;
	localparam logic [7:0] BANK0_BASE    = 8'h00;
	localparam logic [7:0] BANK1_BASE    = 8'h80;

	// Register byte addresses
	localparam logic [11:0] ADDR_FLAGS  = 12'h000;
	localparam logic [11:0] ADDR_RESULT = 12'h004;

	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic       HRESP_OKAY    = 1'h0;

	typedef enum logic [4:0] {
		OP_NONE,
		OP_ADD_W_FILE,
		OP_ADD_LITERAL,
		OP_SUB_FROM_LITERAL,
		OP_SUB_W_FILE,
		OP_AND_W_FILE,
		OP_OR_W_FILE,
		OP_XOR_W_FILE,
		OP_CLEAR_FILE,
		OP_MOVE_W_TO_FILE,
		OP_BIT_CLEAR,
		OP_BIT_SET,
		OP_NIBBLE_SWAP,
		OP_ROTATE_RIGHT,
		OP_ROTATE_LEFT,
		OP_WATCHDOG_KICK,
		OP_LOW_POWER_HALT
	} psf_op_e;

	typedef struct packed {
		logic        valid;
		psf_op_e     op;
		logic        to_flags;
		logic [7:0]  w_val;
		logic [7:0]  file_val;
		logic [7:0]  lit_val;
		logic [2:0]  bit_sel;
		logic [6:0]  file_addr;
	} psf_exec_s;

	typedef struct packed {
		logic null_res;
		logic nibble_carry;
		logic msb_ovf;
	} psf_flags_s;

endpackage

//--- core/psf_top.sv
// Processor status flag register with AHB-Lite access
`timescale 1ns/100ps
module psf_top
	import psf_pkg::*;
(
	input  wire logic        REF_CLK,      // 100 MHz clock
	input  wire logic        RST,          // Synchronous reset, active high
	input  wire psf_exec_s   EXEC,         // Instruction to execute
	input  wire logic        WDT_EXPIRE,   // Watchdog timer expired
	input  wire logic        HSEL,         // AHB select
	input  wire logic [31:0] HADDR,        // AHB address
	input  wire logic [1:0]  HTRANS,       // AHB transfer type
	input  wire logic        HWRITE,       // AHB write
	input  wire logic [2:0]  HSIZE,        // AHB size, word only
	input  wire logic [31:0] HWDATA,       // AHB write data
	input  wire logic        HREADY,       // AHB bus ready
	output logic      [31:0] HRDATA,       // AHB read data
	output logic             HREADYOUT,    // AHB slave ready
	output logic             HRESP,        // AHB response
	output logic      [7:0]  STATUS_FLAGS, // processor_flags contents
	output logic      [7:0]  RESULT,       // Last ALU result
	output logic      [7:0]  DIRECT_ADDR   // Banked direct data address
);

	typedef enum logic [1:0] {
		BUS_IDLE,
		BUS_WRITE,
		BUS_RD_WAIT,
		BUS_RD_DATA
	} psf_bus_e;

	psf_bus_e         bus_r;
	psf_bus_e         bus_nxt;
	logic [11:0]      addr_r;
	logic [11:0]      addr_nxt;
	logic [31:0]      hrdata_r;
	logic [31:0]      hrdata_nxt;
	logic             hready_r;
	logic             hready_nxt;
	logic [7:0]       flags_r;
	logic [7:0]       flags_nxt;
	logic [7:0]       result_r;
	logic [7:0]       result_nxt;
	logic [7:0]       daddr_r;
	logic [7:0]       daddr_nxt;
	logic             accept;
	logic             bus_wr_flags;
	logic [7:0]       alu_res;
	psf_flags_s       alu_flags;
	psf_flags_s       alu_touch;

	function automatic logic writes_file(input psf_op_e op);
		case (op)
			OP_NONE, OP_ADD_LITERAL, OP_SUB_FROM_LITERAL,
			OP_WATCHDOG_KICK, OP_LOW_POWER_HALT: writes_file = 1'b0;
			default:                             writes_file = 1'b1;
		endcase
	endfunction

	function automatic logic [7:0] bank_addr(input logic bank, input logic [6:0] low);
		bank_addr = (bank ? BANK1_BASE : BANK0_BASE) | {1'b0, low};
	endfunction

	psf_alu #(
		.WIDTH (FLAG_W)
	) u_alu (
		.op       (EXEC.op),
		.w_val    (EXEC.w_val),
		.file_val (EXEC.file_val),
		.lit_val  (EXEC.lit_val),
		.bit_sel  (EXEC.bit_sel),
		.carry_in (flags_r[BIT_MSB_OVF]),
		.result   (alu_res),
		.flags    (alu_flags),
		.touch    (alu_touch)
	);

	assign accept = HSEL && HREADY && (HTRANS == HTRANS_NONSEQ);
	assign bus_wr_flags = (bus_r == BUS_WRITE) && (addr_r == ADDR_FLAGS);

	// Bus slave: writes take no wait, reads one wait state
	always_comb begin
		bus_nxt = bus_r;
		addr_nxt = addr_r;
		hrdata_nxt = hrdata_r;
		hready_nxt = 1'b1;
		case (bus_r)
			BUS_RD_WAIT: begin
				bus_nxt = BUS_RD_DATA;
				case (addr_r)
					ADDR_FLAGS:  hrdata_nxt = {24'h000000, flags_r};
					ADDR_RESULT: hrdata_nxt = {24'h000000, result_r};
					default:     hrdata_nxt = 32'h00000000;
				endcase
			end
			default: begin
				bus_nxt = BUS_IDLE;
				if (accept) begin
					addr_nxt = HADDR[ADDR_W-1:0];
					bus_nxt = HWRITE ? BUS_WRITE : BUS_RD_WAIT;
					hready_nxt = HWRITE;
				end
			end
		endcase
	end

	// Flag register update
	always_comb begin
		flags_nxt = flags_r;
		result_nxt = result_r;
		daddr_nxt = daddr_r;
		if (bus_wr_flags) begin
			flags_nxt = (HWDATA[7:0] & ~HW_ONLY_MASK) | (flags_r & HW_ONLY_MASK);
		end
		if (EXEC.valid) begin
			result_nxt = alu_res;
			daddr_nxt = bank_addr(flags_r[BIT_BANK], EXEC.file_addr);
			if (EXEC.to_flags && writes_file(EXEC.op)) begin
				flags_nxt = (alu_res & ~HW_ONLY_MASK) | (flags_nxt & HW_ONLY_MASK);
				if (alu_touch != '0) begin
					flags_nxt[BIT_NULL:BIT_MSB_OVF] = {flags_r[BIT_NULL],
						flags_r[BIT_NIBBLE], flags_r[BIT_MSB_OVF]};
				end
			end
			if (alu_touch.null_res) begin
				flags_nxt[BIT_NULL] = alu_flags.null_res;
			end
			if (alu_touch.nibble_carry) begin
				flags_nxt[BIT_NIBBLE] = alu_flags.nibble_carry;
			end
			if (alu_touch.msb_ovf) begin
				flags_nxt[BIT_MSB_OVF] = alu_flags.msb_ovf;
			end
			case (EXEC.op)
				OP_WATCHDOG_KICK: begin
					flags_nxt[BIT_TIMEOUT] = 1'b1;
					flags_nxt[BIT_PWR_DOWN] = 1'b1;
				end
				OP_LOW_POWER_HALT: begin
					flags_nxt[BIT_TIMEOUT] = 1'b1;
					flags_nxt[BIT_PWR_DOWN] = 1'b0;
				end
				default: begin
					flags_nxt[BIT_TIMEOUT] = flags_nxt[BIT_TIMEOUT];
				end
			endcase
		end
		if (WDT_EXPIRE) begin
			flags_nxt[BIT_TIMEOUT] = 1'b0;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			bus_r <= BUS_IDLE;
			addr_r <= 12'h000;
			hrdata_r <= 32'h00000000;
			hready_r <= 1'b1;
			flags_r <= FLAGS_RST;
			result_r <= 8'h00;
			daddr_r <= 8'h00;
		end else begin
			bus_r <= bus_nxt;
			addr_r <= addr_nxt;
			hrdata_r <= hrdata_nxt;
			hready_r <= hready_nxt;
			flags_r <= flags_nxt;
			result_r <= result_nxt;
			daddr_r <= daddr_nxt;
		end
	end

	assign HRDATA = hrdata_r;
	assign HREADYOUT = hready_r;
	assign HRESP = HRESP_OKAY;
	assign STATUS_FLAGS = flags_r;
	assign RESULT = result_r;
	assign DIRECT_ADDR = daddr_r;

	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (RST);

	logic quiet;
	assign quiet = !bus_wr_flags && !WDT_EXPIRE;

	sequence s_read_taken;
		accept && !HWRITE;
	endsequence

	sequence s_read_answer;
		!HREADYOUT ##1 HREADYOUT;
	endsequence

	chk_read_timing: assert property (s_read_taken |=> s_read_answer)
		else $error("read answer not after one wait state");

	chk_hw_bits_locked: assert property (
		bus_wr_flags && !EXEC.valid && !WDT_EXPIRE
		|=> flags_r[BIT_TIMEOUT:BIT_PWR_DOWN] == $past(flags_r[BIT_TIMEOUT:BIT_PWR_DOWN]))
		else $error("software write changed hardware-owned bits");

	chk_bus_write_lands: assert property (
		bus_wr_flags && !EXEC.valid
		|=> flags_r[BIT_IND_RSV:BIT_BANK] == $past(HWDATA[7:5])
		&& flags_r[BIT_NULL:BIT_MSB_OVF] == $past(HWDATA[2:0]))
		else $error("bus write did not reach status");

	chk_clear_pattern: assert property (
		EXEC.valid && EXEC.op == OP_CLEAR_FILE && EXEC.to_flags && quiet
		|=> flags_r == {3'h0, $past(flags_r[4:3]), 1'b1, $past(flags_r[1:0])})
		else $error("clear of status gave wrong pattern");

	chk_add_carry: assert property (
		EXEC.valid && EXEC.op == OP_ADD_W_FILE && quiet
		|=> flags_r[BIT_MSB_OVF] == ((9'($past(EXEC.w_val)) + 9'($past(EXEC.file_val))) > 9'h0ff))
		else $error("add carry wrong");

	chk_nibble_carry: assert property (
		EXEC.valid && EXEC.op == OP_ADD_LITERAL && quiet
		|=> flags_r[BIT_NIBBLE] == ((5'($past(EXEC.w_val[3:0])) + 5'($past(EXEC.lit_val[3:0])))
		> 5'h0f))
		else $error("nibble carry wrong");

	chk_sub_borrow: assert property (
		EXEC.valid && EXEC.op == OP_SUB_W_FILE && quiet
		|=> flags_r[BIT_MSB_OVF] == ($past(EXEC.file_val) >= $past(EXEC.w_val)))
		else $error("borrow polarity wrong");

	chk_null_result: assert property (
		EXEC.valid && alu_touch.null_res && quiet
		|=> flags_r[BIT_NULL] == (RESULT == 8'h00))
		else $error("null result bit wrong");

	chk_rotate_out: assert property (
		EXEC.valid && EXEC.op == OP_ROTATE_RIGHT && quiet
		|=> flags_r[BIT_MSB_OVF] == $past(EXEC.file_val[0]))
		else $error("rotate carry wrong");

	chk_halt_flags: assert property (
		EXEC.valid && EXEC.op == OP_LOW_POWER_HALT && !WDT_EXPIRE
		|=> !flags_r[BIT_PWR_DOWN] && flags_r[BIT_TIMEOUT])
		else $error("halt flags wrong");

	chk_wdt_clear: assert property (
		WDT_EXPIRE |=> !flags_r[BIT_TIMEOUT])
		else $error("watchdog expiry did not clear timeout");

	chk_expiry_keeps_pd: assert property (
		WDT_EXPIRE && !EXEC.valid
		|=> flags_r[BIT_PWR_DOWN] == $past(flags_r[BIT_PWR_DOWN]))
		else $error("watchdog expiry changed power-down bit");

	chk_bank_addr: assert property (
		EXEC.valid |=> DIRECT_ADDR == {$past(flags_r[BIT_BANK]), $past(EXEC.file_addr)})
		else $error("direct address bank wrong");

	chk_write_no_wait: assert property (
		accept && HWRITE |=> HREADYOUT)
		else $error("write inserted a wait state");

	chk_read_data: assert property (
		s_read_taken ##0 HADDR[ADDR_W-1:0] == ADDR_FLAGS
		|-> ##2 HRDATA == {24'h000000, $past(STATUS_FLAGS)})
		else $error("read data does not match status");

	chk_kick_flags: assert property (
		EXEC.valid && EXEC.op == OP_WATCHDOG_KICK && !WDT_EXPIRE
		|=> flags_r[BIT_PWR_DOWN] && flags_r[BIT_TIMEOUT])
		else $error("watchdog kick flags wrong");

	chk_instr_hw_locked: assert property (
		EXEC.valid && EXEC.to_flags && writes_file(EXEC.op) && !WDT_EXPIRE
		|=> flags_r[BIT_TIMEOUT:BIT_PWR_DOWN] == $past(flags_r[BIT_TIMEOUT:BIT_PWR_DOWN]))
		else $error("instruction changed hardware-owned bits");

	chk_dest_keeps_carry: assert property (
		EXEC.valid && EXEC.to_flags && quiet
		&& (EXEC.op == OP_CLEAR_FILE || EXEC.op == OP_AND_W_FILE)
		|=> flags_r[BIT_NIBBLE:BIT_MSB_OVF] == $past(flags_r[BIT_NIBBLE:BIT_MSB_OVF]))
		else $error("status destination overwrote carry flags");

	chk_rotl_out: assert property (
		EXEC.valid && EXEC.op == OP_ROTATE_LEFT && quiet
		|=> flags_r[BIT_MSB_OVF] == $past(EXEC.file_val[FLAG_W-1]))
		else $error("rotate left carry wrong");

	chk_sub_lit_borrow: assert property (
		EXEC.valid && EXEC.op == OP_SUB_FROM_LITERAL && quiet
		|=> flags_r[BIT_MSB_OVF] == ($past(EXEC.lit_val) >= $past(EXEC.w_val)))
		else $error("literal subtract borrow wrong");

	chk_sub_nibble: assert property (
		EXEC.valid && EXEC.op == OP_SUB_W_FILE && quiet
		|=> flags_r[BIT_NIBBLE] == ($past(EXEC.file_val[NIB_W-1:0]) >= $past(EXEC.w_val[NIB_W-1:0])))
		else $error("digit borrow polarity wrong");

endmodule

//--- testbench/tb_psf_top.sv
// Self-checking testbench for the processor status flag block
`timescale 1ns/100ps
module tb_psf_top
	import psf_pkg::*;
;
	logic        REF_CLK;
	logic        RST;
	psf_exec_s   EXEC;
	logic        WDT_EXPIRE;
	logic        HSEL;
	logic [31:0] HADDR;
	logic [1:0]  HTRANS;
	logic        HWRITE;
	logic [2:0]  HSIZE;
	logic [31:0] HWDATA;
	logic [31:0] HRDATA;
	logic        HREADYOUT;
	logic        HRESP;
	logic [7:0]  STATUS_FLAGS;
	logic [7:0]  RESULT;
	logic [7:0]  DIRECT_ADDR;
	logic [31:0] rd;
	int          err_count;
	int          cmp_count;

	psf_top psf_top_i (
		.REF_CLK      (REF_CLK),
		.RST          (RST),
		.EXEC         (EXEC),
		.WDT_EXPIRE   (WDT_EXPIRE),
		.HSEL         (HSEL),
		.HADDR        (HADDR),
		.HTRANS       (HTRANS),
		.HWRITE       (HWRITE),
		.HSIZE        (HSIZE),
		.HWDATA       (HWDATA),
		.HREADY       (HREADYOUT),
		.HRDATA       (HRDATA),
		.HREADYOUT    (HREADYOUT),
		.HRESP        (HRESP),
		.STATUS_FLAGS (STATUS_FLAGS),
		.RESULT       (RESULT),
		.DIRECT_ADDR  (DIRECT_ADDR)
	);

	always #5 REF_CLK = ~REF_CLK;

	task automatic complete_run();
		$display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
			err_count++;
		end
	endtask

	// Waits for hready sampled high, bounded
	task automatic wait_ready();
		int n;
		n = 0;
		do begin
			@(posedge REF_CLK);
			n++;
		end while (HREADYOUT !== 1'b1 && n < 50);
		if (HREADYOUT !== 1'b1) begin
			err_count++;
			complete_run();
		end
	endtask

	task automatic ahb(input logic w, input logic [11:0] a, input logic [31:0] wd);
		HSEL   <= 1'b1;
		HTRANS <= HTRANS_NONSEQ;
		HADDR  <= {20'h0, a};
		HWRITE <= w;
		HSIZE  <= 3'h2;
		wait_ready();
		HSEL   <= 1'b0;
		HTRANS <= 2'h0;
		HWDATA <= wd;
		wait_ready();
		rd = HRDATA;
		@(posedge REF_CLK);
	endtask

	task automatic exec(input psf_op_e op, input logic tf, input logic [7:0] w, f,
		input logic [6:0] a);
		EXEC <= '{1'b1, op, tf, w, f, f, 3'h0, a};
		@(posedge REF_CLK);
		EXEC.valid <= 1'b0;
		@(posedge REF_CLK);
	endtask

	task automatic exec_bit(input psf_op_e op, input logic [7:0] f, input logic [2:0] b);
		EXEC <= '{1'b1, op, 1'b1, 8'h00, f, f, b, 7'h00};
		@(posedge REF_CLK);
		EXEC.valid <= 1'b0;
		@(posedge REF_CLK);
	endtask

	function automatic logic [10:0] alu_ref(input logic [7:0] a, b, input logic sub);
		logic [8:0] s;
		logic [4:0] n;
		logic [7:0] bb;
		bb = sub ? ~b : b;
		s = {1'b0, a} + {1'b0, bb} + {8'h00, sub};
		n = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, sub};
		return {s[7:0], s[7:0] == 8'h00, n[4], s[8]};
	endfunction

	task automatic t_reset();
		check(STATUS_FLAGS, 8'h18);
		check({RESULT, DIRECT_ADDR}, 16'h0000);
		check({HRDATA[0], HREADYOUT, HRESP}, 3'h2);
		$display("Test reset done");
	endtask

	task automatic t_bus();
		ahb(1'b1, 12'h000, 32'h0000_0000);
		check(STATUS_FLAGS, 8'h18);
		ahb(1'b1, 12'h000, 32'h0000_0027);
		check(STATUS_FLAGS, 8'h3f);
		ahb(1'b0, 12'h000, 32'h0);
		check(rd, 32'h0000_003f);
		ahb(1'b1, 12'h008, 32'h0000_0000);
		ahb(1'b0, 12'h008, 32'h0);
		check(rd, 32'h0);
		check(STATUS_FLAGS, 8'h3f);
		$display("Test bus done");
	endtask

	task automatic t_arith();
		psf_op_e    ops[4] = '{OP_ADD_W_FILE, OP_ADD_LITERAL, OP_SUB_FROM_LITERAL, OP_SUB_W_FILE};
		logic [7:0] wv[3]  = '{8'h01, 8'h05, 8'h00};
		logic [7:0] ov[3]  = '{8'hff, 8'h03, 8'h00};
		logic [10:0] e;
		for (int i = 0; i < 4; i++) begin
			for (int j = 0; j < 3; j++) begin
				e = (i < 2) ? alu_ref(wv[j], ov[j], 1'b0) : alu_ref(ov[j], wv[j], 1'b1);
				exec(ops[i], 1'b0, wv[j], ov[j], 7'h00);
				check(RESULT, e[10:3]);
				check(STATUS_FLAGS[2:0], e[2:0]);
			end
		end
		exec(OP_AND_W_FILE, 1'b0, 8'hf0, 8'h0f, 7'h00);
		check(STATUS_FLAGS[2:0], {1'b1, e[1:0]});
		$display("Test arith done");
	endtask

	task automatic t_rotate();
		exec(OP_ADD_W_FILE, 1'b0, 8'hff, 8'h01, 7'h00);
		exec(OP_ROTATE_RIGHT, 1'b0, 8'h00, 8'h02, 7'h00);
		check({RESULT, STATUS_FLAGS[0]}, 9'h102);
		exec(OP_ROTATE_LEFT, 1'b0, 8'h00, 8'h80, 7'h00);
		check({RESULT, STATUS_FLAGS[0]}, 9'h001);
		$display("Test rotate done");
	endtask

	task automatic t_dest();
		ahb(1'b1, 12'h000, 32'h0000_0023);
		check(STATUS_FLAGS, 8'h3b);
		exec(OP_CLEAR_FILE, 1'b1, 8'h00, 8'h55, 7'h00);
		check(STATUS_FLAGS, 8'h1f);
		exec(OP_ADD_W_FILE, 1'b1, 8'h10, 8'hf0, 7'h00);
		check(STATUS_FLAGS, 8'h1d);
		exec(OP_MOVE_W_TO_FILE, 1'b1, 8'h27, 8'h00, 7'h00);
		check(STATUS_FLAGS, 8'h3f);
		$display("Test destination done");
	endtask

	task automatic t_power();
		exec(OP_LOW_POWER_HALT, 1'b0, 8'h00, 8'h00, 7'h00);
		check(STATUS_FLAGS[4:3], 2'h2);
		WDT_EXPIRE <= 1'b1;
		@(posedge REF_CLK);
		WDT_EXPIRE <= 1'b0;
		@(posedge REF_CLK);
		check(STATUS_FLAGS[4:3], 2'h0);
		exec(OP_WATCHDOG_KICK, 1'b0, 8'h00, 8'h00, 7'h00);
		check(STATUS_FLAGS[4:3], 2'h3);
		$display("Test power done");
	endtask

	task automatic t_bank();
		ahb(1'b1, 12'h000, 32'h0000_0020);
		exec(OP_MOVE_W_TO_FILE, 1'b0, 8'h00, 8'h00, 7'h05);
		check(DIRECT_ADDR, 8'h85);
		ahb(1'b1, 12'h000, 32'h0000_0000);
		exec(OP_MOVE_W_TO_FILE, 1'b0, 8'h00, 8'h00, 7'h7f);
		check(DIRECT_ADDR, 8'h7f);
		$display("Test bank done");
	endtask

	task automatic t_neutral();
		exec_bit(OP_BIT_SET, 8'h18, 3'h5);
		check(STATUS_FLAGS, 8'h38);
		exec_bit(OP_BIT_CLEAR, 8'h38, 3'h3);
		check(STATUS_FLAGS, 8'h38);
		exec_bit(OP_BIT_CLEAR, 8'h38, 3'h5);
		check(STATUS_FLAGS, 8'h18);
		exec_bit(OP_NIBBLE_SWAP, 8'h21, 3'h0);
		check(STATUS_FLAGS, 8'h1a);
		exec(OP_OR_W_FILE, 1'b0, 8'h00, 8'h00, 7'h00);
		check({RESULT, STATUS_FLAGS[2:0]}, 11'h006);
		exec(OP_XOR_W_FILE, 1'b0, 8'h5a, 8'h0f, 7'h00);
		check({RESULT, STATUS_FLAGS[2:0]}, 11'h2aa);
		ahb(1'b0, 12'h004, 32'h0);
		check(rd, 32'h0000_0055);
		$display("Test neutral done");
	endtask

	initial begin
		REF_CLK    = 1'b0;
		RST        = 1'b1;
		EXEC       = '0;
		WDT_EXPIRE = 1'b0;
		HSEL       = 1'b0;
		HADDR      = 32'h0;
		HTRANS     = 2'h0;
		HWRITE     = 1'b0;
		HSIZE      = 3'h2;
		HWDATA     = 32'h0;
		err_count  = 0;
		cmp_count  = 0;
		repeat (16) @(posedge REF_CLK);
		RST <= 1'b0;
		@(posedge REF_CLK);
		t_reset();
		t_bus();
		t_arith();
		t_rotate();
		t_dest();
		t_power();
		t_bank();
		t_neutral();
		complete_run();
	end
endmodule
